/* File: hw/iotc_pkg.sv */
// Constants shared by the auxiliary I/O interrupt and terminate control.
// Assumes a 20 MHz mclk and a 5-bit time-slot code from the sequence clock.
package iotc_pkg;

  // Time slot code: (major - 1) * 4 + (minor - 1)
  localparam logic [4:0] PH_1_1 = 5'h00;
  localparam logic [4:0] PH_1_2 = 5'h01;
  localparam logic [4:0] PH_1_3 = 5'h02;
  localparam logic [4:0] PH_2_1 = 5'h04;
  localparam logic [4:0] PH_2_2 = 5'h05;
  localparam logic [4:0] PH_2_3 = 5'h06;
  localparam logic [4:0] PH_3_2 = 5'h09;
  localparam logic [4:0] PH_3_3 = 5'h0A;
  localparam logic [4:0] PH_3_4 = 5'h0B;
  localparam logic [4:0] PH_4_2 = 5'h0D;
  localparam logic [4:0] PH_4_4 = 5'h0F;
  localparam logic [4:0] PH_5_1 = 5'h10;
  localparam logic [4:0] PH_5_4 = 5'h13;
  localparam logic [4:0] PH_6_1 = 5'h14;
  localparam logic [4:0] PH_6_4 = 5'h17;

  // Memory locations of the interrupt control words
  localparam logic [14:0] INT_CW1_ADDR = 15'h002A;
  localparam logic [14:0] INT_CW2_ADDR = 15'h002B;

  // Control word fields
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 13;
  localparam int TALLY_LSB = 14;
  localparam int TALLY_MSB = 23;
  localparam int CW_FIRST_BIT = 21;
  localparam int MARKER_BIT = 1;
  localparam int WATCH_1BIT = 23;
  localparam int WATCH_2BIT = 11;
  localparam int WATCH_3BIT = 7;

  // Reader external-function instruction bits
  localparam int EF_CHAR_MSB = 7;
  localparam int EF_FUNC_BIT = 7;
  localparam int EF_LOCK_BIT = 8;
  localparam int EF_OUT_BIT = 9;
  localparam int EF_IN_BIT = 10;

  // Console translation
  localparam int NCON = 4;
  localparam int CON_DIR_BIT = 4;
  localparam logic [1:0] MODE_1BIT = 2'h0;
  localparam logic [1:0] MODE_2BIT = 2'h1;
  localparam logic [1:0] MODE_3BIT = 2'h2;
  localparam logic [3:0] WIDTH_1 = 4'h1;
  localparam logic [3:0] WIDTH_2 = 4'h2;
  localparam logic [3:0] WIDTH_3 = 4'h3;
  localparam logic [3:0] WIDTH_6 = 4'h6;
  localparam logic [3:0] WIDTH_8 = 4'h8;

  // Timing
  localparam int CLK_NS = 50;
  localparam int HALF_MS_NS = 500000;
  localparam int EF_PULSE_NS = 4000;
  localparam int HALF_MS_CYC = HALF_MS_NS / CLK_NS;
  localparam int EF_PULSE_CYC = EF_PULSE_NS / CLK_NS;

endpackage : iotc_pkg

/* File: hw/iotc_con_if.sv */
// Carrier between the core and the console translation module.
// Assumes both ends run on mclk.
`timescale 1ns/10ps
interface iotc_con_if;
  logic grant;
  logic xfer;
  logic [23:0] cw;
  logic [23:0] dest;
  logic serpar;
  logic bitsel;
  logic [3:0] gate;
  logic dir_in;
  logic [3:0] equip;
  logic [3:0] width;
  logic set_b21;
  logic marker;
  logic update;
  logic clr_b21;

  modport core (output grant, xfer, cw, dest, serpar, bitsel,
                input gate, dir_in, equip, width, set_b21, marker, update, clr_b21);
  modport con (input grant, xfer, cw, dest, serpar, bitsel,
               output gate, dir_in, equip, width, set_b21, marker, update, clr_b21);
endinterface : iotc_con_if

/* File: hw/iotc_console.sv */
// Console priority, address translator and input terminate logic.
// Assumes request and address pins are asynchronous; other inputs on mclk.
`timescale 1ns/10ps
module iotc_console
  import iotc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [NCON-1:0] con_req,
  input wire logic [NCON*5-1:0] con_addr,
  iotc_con_if.con cif
);

  typedef struct packed {
    logic [NCON-1:0] rq1, rq2, rq3, rqf;
    logic [NCON*5-1:0] ad1, ad2, ad3, adf;
    logic [3:0] gate;
    logic dir_in;
    logic [3:0] equip;
    logic [3:0] width;
    logic set_b21, marker, update, clr_b21;
  } iotc_con_st_type;

  iotc_con_st_type r, n;
  logic [4:0] sel_addr;
  logic watch;

  // Next state
  always_comb begin
    n = r;
    n.set_b21 = 1'b0;
    n.marker = 1'b0;
    n.update = 1'b0;
    n.clr_b21 = 1'b0;
    sel_addr = 5'h00;
    watch = 1'b0;
    // Three-stage synchronisers, change taken once stages two and three agree
    n.rq1 = con_req;
    n.rq2 = r.rq1;
    n.rq3 = r.rq2;
    n.rqf = (r.rq2 & r.rq3) | (r.rqf & (r.rq2 | r.rq3));
    n.ad1 = con_addr;
    n.ad2 = r.ad1;
    n.ad3 = r.ad2;
    n.adf = (r.ad2 & r.ad3) | (r.adf & (r.ad2 | r.ad3));
    // Fixed priority, lowest console wins
    n.gate = 4'h0;
    if (cif.grant) begin
      for (int i = NCON - 1; i >= 0; i--) begin
        if (r.rqf[i]) begin
          n.gate = 4'(1 << i);
          sel_addr = r.adf[i*5 +: 5];
        end
      end
      n.dir_in = sel_addr[CON_DIR_BIT];
      n.equip = sel_addr[3:0];
    end
    // Serial width from the mode field, parallel width from the selector
    if (cif.serpar) begin
      n.width = cif.bitsel ? WIDTH_8 : WIDTH_6;
    end else begin
      case (cif.cw[TALLY_LSB +: 2])
        MODE_2BIT: n.width = WIDTH_2;
        MODE_3BIT: n.width = WIDTH_3;
        default: n.width = WIDTH_1;
      endcase
    end
    // Marker insertion and arrival watch
    case (cif.cw[TALLY_LSB +: 2])
      MODE_2BIT: watch = cif.dest[WATCH_2BIT];
      MODE_3BIT: watch = cif.dest[WATCH_3BIT];
      default: watch = cif.dest[WATCH_1BIT];
    endcase
    if (cif.xfer) begin
      if (!cif.cw[CW_FIRST_BIT]) begin
        n.set_b21 = 1'b1;
        n.marker = 1'b1;
      end else if (watch) begin
        n.update = 1'b1;
        n.clr_b21 = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign cif.gate = r.gate;
  assign cif.dir_in = r.dir_in;
  assign cif.equip = r.equip;
  assign cif.width = r.width;
  assign cif.set_b21 = r.set_b21;
  assign cif.marker = r.marker;
  assign cif.update = r.update;
  assign cif.clr_b21 = r.clr_b21;

endmodule : iotc_console

/* File: hw/iotc_top.sv */
// Auxiliary I/O control: time base interrupt, buffer terminate, reader
// enables and console translation.
// Assumes phase and sequence inputs come from the sequence clock on mclk;
// oscillator, reader and console pins are asynchronous.
//
// Operation
// - 6.4 clears S,Z; 1.1 loads 43.
// - 1.2 clears holding register and arm.
// - Save P to 43, load P from operand.
// - Clear D, end sequence, then fetch or RC1.
// - Service sequence only when tally is zero.
// - Armed and oscillator low sets one-shot.
// - One-shot clears: disarm, zero count, resync.
// - Resync sets 3.4 after half ms, clears 4.2.
// - One-shot stays clear until re-armed.
// - Terminate sets 4.4 RC2, clears 6.4 write.
// - Signal terminate; stop shift in area mode.
// - Console priority selects one, enables its gates.
// - Decode console address into direction, equipment.
// - Input width from serial mode or selector.
// - First input sets bit 21 and marker.
// - Marker at watch bit updates, clears bit 21.
// - Char at 3.3, enable bits at 5.1.
// - Bit 7 sets function flop, 4 us signal.
// - Bit 8 sets lockout until first 4.2 after a start.
// - Bit 9 sets output enable, clears exhausted; the code only sets the enable and keeps no exhausted flag.
// - Bit 10 sets input enable, clears full; the code only sets the enable and keeps no full flag.
`timescale 1ns/10ps
module iotc_top
  import iotc_pkg::*;
#(
  parameter int HALF_MS_CYCLES = HALF_MS_CYC
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic phase_tick,
  input wire logic [4:0] phase,
  input wire logic scan_seq,
  input wire logic rw_seq,
  input wire logic wc_seq,
  input wire logic rc2_seq,
  input wire logic write_seq,
  input wire logic seq_start,
  input wire logic int_op,
  input wire logic int_grant,
  input wire logic io_req_pending,
  input wire logic arm_set,
  input wire logic disarm,
  input wire logic [23:0] cw42_word,
  input wire logic [13:0] prog_addr_in,
  input wire logic [23:0] operand_in,
  input wire logic cw_wc_zero,
  input wire logic shift_area_mode,
  input wire logic osc_pin,
  input wire logic exf_rseq,
  input wire logic paper_tape_unit_sel,
  input wire logic [10:0] instr,
  input wire logic ack_enable,
  input wire logic rdr_out_req_pin,
  input wire logic rdr_in_req_pin,
  input wire logic [NCON-1:0] con_req,
  input wire logic [NCON*5-1:0] con_addr,
  input wire logic con_grant,
  input wire logic con_xfer,
  input wire logic [23:0] con_cw,
  input wire logic [23:0] con_dest,
  input wire logic con_serpar,
  input wire logic con_bitsel,
  output logic interrupt_service_sequence,
  output logic [14:0] mem_addr,
  output logic [23:0] mem_data,
  output logic [13:0] prog_addr,
  output logic prog_addr_load,
  output logic strobe_upper,
  output logic operand_clear,
  output logic ifetch_enable_set,
  output logic first_control_word_read_start,
  output logic int_armed,
  output logic int_oneshot,
  output logic int_resync,
  output logic buf_term,
  output logic shift_stop,
  output logic [7:0] char_out,
  output logic rdr_ext_func,
  output logic rdr_lockout,
  output logic rdr_input_active,
  output logic rdr_out_accept,
  output logic rdr_in_accept,
  output logic [NCON-1:0] con_gate,
  output logic con_dir_in,
  output logic [3:0] con_equip,
  output logic [3:0] con_width,
  output logic con_set_b21,
  output logic con_marker,
  output logic con_update,
  output logic con_clr_b21
);

  localparam int OSC = 0;
  localparam int RDO = 1;
  localparam int RDI = 2;

  typedef struct packed {
    logic [2:0] sy1, sy2, sy3, filt;
    logic arm, spent, oneshot, half_done, hit, resync;
    logic [15:0] age;
    logic svc, svc_end;
    logic [23:0] x;
    logic [14:0] s;
    logic [23:0] z;
    logic [13:0] p;
    logic p_load, strobe, d_clear, ifetch_set, rc1_start;
    logic buf_term, shift_stop;
    logic [7:0] char_out;
    logic ef, ef_sig, lockout, lock_wait, out_en, in_en, out_ok, in_ok;
    logic [7:0] ef_cnt;
  } iotc_top_st_type;

  iotc_top_st_type r, n;
  logic tick_rdr;

  iotc_con_if cif ();

  ////////////////////////////////////////////////////////////////////////
  // Console translation

  assign cif.grant = con_grant;
  assign cif.xfer = con_xfer;
  assign cif.cw = con_cw;
  assign cif.dest = con_dest;
  assign cif.serpar = con_serpar;
  assign cif.bitsel = con_bitsel;

  iotc_console u_console (
    .mclk(mclk),
    .srst(srst),
    .con_req(con_req),
    .con_addr(con_addr),
    .cif(cif)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    n.p_load = 1'b0;
    n.strobe = 1'b0;
    n.d_clear = 1'b0;
    n.ifetch_set = 1'b0;
    n.rc1_start = 1'b0;
    tick_rdr = phase_tick & exf_rseq & paper_tape_unit_sel;

    // Three-stage synchronisers, change taken once stages two and three agree
    n.sy1 = {rdr_in_req_pin, rdr_out_req_pin, osc_pin};
    n.sy2 = r.sy1;
    n.sy3 = r.sy2;
    n.filt = (r.sy2 & r.sy3) | (r.filt & (r.sy2 | r.sy3));

    // Arm control; a re-arm releases the spent one-shot
    if (r.svc && phase_tick && phase == PH_1_2) begin
      n.x = 24'h000000;
      n.arm = 1'b0;
    end
    if (disarm) begin
      n.arm = 1'b0;
      n.oneshot = 1'b0;
    end
    if (arm_set) begin
      n.arm = 1'b1;
      n.spent = 1'b0;
    end

    // One-shot and its half millisecond age
    if (r.oneshot) begin
      if (r.age >= 16'(HALF_MS_CYCLES - 1)) begin
        n.half_done = 1'b1;
      end else begin
        n.age = r.age + 16'h0001;
      end
    end else if (r.arm && !r.spent && !r.filt[OSC] && !disarm) begin
      n.oneshot = 1'b1;
      n.age = 16'h0000;
      n.half_done = 1'b0;
      n.hit = 1'b0;
    end

    // Resync flop marks the interrupt to I/O priority
    if (phase_tick && phase == PH_3_4 && scan_seq && r.oneshot && r.half_done) begin
      n.resync = 1'b1;
      n.hit = 1'b1;
    end
    if (phase_tick && phase == PH_4_2 && r.resync) begin
      n.resync = 1'b0;
    end
    if (phase_tick && phase == PH_1_3 && r.hit && r.oneshot && (rw_seq || wc_seq || r.svc)) begin
      n.oneshot = 1'b0;
      n.spent = 1'b1;
      n.hit = 1'b0;
    end

    // Service sequence entry at 6.4 when the tally is zero
    if (phase_tick && phase == PH_6_4 && int_op && !r.svc &&
        cw42_word[TALLY_MSB:TALLY_LSB] == 10'h000) begin
      n.svc = 1'b1;
      n.s = 15'h0000;
      n.z = 24'h000000;
      n.oneshot = 1'b0;
      n.spent = 1'b1;
    end

    // Service sequence steps
    if (r.svc && phase_tick) begin
      case (phase)
        PH_1_1: n.s = INT_CW2_ADDR;
        PH_1_3: n.x = {10'h000, prog_addr_in};
        PH_2_1: n.z[ADDR_MSB:ADDR_LSB] = r.x[ADDR_MSB:ADDR_LSB];
        PH_2_2: begin
          n.strobe = 1'b1;
          n.p = 14'h0000;
        end
        PH_2_3: begin
          n.p = operand_in[ADDR_MSB:ADDR_LSB];
          n.p_load = 1'b1;
        end
        PH_3_2: n.d_clear = 1'b1;
        PH_5_4: begin
          n.svc = 1'b0;
          n.svc_end = 1'b1;
        end
        default: n.svc = r.svc;
      endcase
    end
    if (r.svc_end && phase_tick && phase == PH_6_1) begin
      n.svc_end = 1'b0;
      n.rc1_start = io_req_pending;
      n.ifetch_set = !io_req_pending;
    end

    // Buffer terminate; a set in the same slot wins over the clear
    if (phase_tick && phase == PH_6_4 && write_seq) begin
      n.buf_term = 1'b0;
      n.shift_stop = 1'b0;
    end
    if (phase_tick && phase == PH_4_4 && rc2_seq && cw_wc_zero && !int_grant) begin
      n.buf_term = 1'b1;
      n.shift_stop = shift_area_mode;
    end

    // Reader character and enable flops
    if (tick_rdr && phase == PH_3_3) begin
      n.char_out = instr[EF_CHAR_MSB:0];
    end
    if (tick_rdr && phase == PH_5_1) begin
      if (instr[EF_FUNC_BIT]) begin
        n.ef = 1'b1;
        n.ef_cnt = 8'(EF_PULSE_CYC);
      end
      if (instr[EF_LOCK_BIT]) begin
        n.lockout = 1'b1;
        n.lock_wait = 1'b1;
      end
      if (instr[EF_OUT_BIT]) begin
        n.out_en = 1'b1;
      end
      if (instr[EF_IN_BIT]) begin
        n.in_en = 1'b1;
      end
    end else begin
      if (r.ef && r.ef_cnt == 8'h00) begin
        n.ef = 1'b0;
      end
      if (r.lockout && seq_start) begin
        n.lock_wait = 1'b0;
      end
      if (r.lockout && !r.lock_wait && phase_tick && phase == PH_4_2) begin
        n.lockout = 1'b0;
      end
      if (r.out_en && r.filt[RDO] && r.buf_term) begin
        n.out_en = 1'b0;
      end
      if (r.in_en && r.filt[RDI] && r.buf_term) begin
        n.in_en = 1'b0;
      end
    end
    if (r.ef && r.ef_cnt != 8'h00) begin
      n.ef_cnt = r.ef_cnt - 8'h01;
    end
    n.ef_sig = r.ef && r.ef_cnt != 8'h00 && ack_enable;

    // Reader requests are blocked while the function flop is set
    n.out_ok = r.filt[RDO] && r.out_en && !r.ef && !r.buf_term;
    n.in_ok = r.filt[RDI] && r.in_en && !r.ef && !r.buf_term;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign interrupt_service_sequence = r.svc;
  assign mem_addr = r.s;
  assign mem_data = r.z;
  assign prog_addr = r.p;
  assign prog_addr_load = r.p_load;
  assign strobe_upper = r.strobe;
  assign operand_clear = r.d_clear;
  assign ifetch_enable_set = r.ifetch_set;
  assign first_control_word_read_start = r.rc1_start;
  assign int_armed = r.arm;
  assign int_oneshot = r.oneshot;
  assign int_resync = r.resync;
  assign buf_term = r.buf_term;
  assign shift_stop = r.shift_stop;
  assign char_out = r.char_out;
  assign rdr_ext_func = r.ef_sig;
  assign rdr_lockout = r.lockout;
  assign rdr_input_active = r.in_en;
  assign rdr_out_accept = r.out_ok;
  assign rdr_in_accept = r.in_ok;
  assign con_gate = cif.gate;
  assign con_dir_in = cif.dir_in;
  assign con_equip = cif.equip;
  assign con_width = cif.width;
  assign con_set_b21 = cif.set_b21;
  assign con_marker = cif.marker;
  assign con_update = cif.update;
  assign con_clr_b21 = cif.clr_b21;

endmodule : iotc_top

/* File: verif/iotc_checker.sv */
// Concurrent checks on the auxiliary I/O control top-level ports.
// Assumes the single mclk domain and the synchronous srst of the design.
`timescale 1ns/10ps
module iotc_checker
  import iotc_pkg::*;
#(
  parameter int HALF_MS_CYCLES = HALF_MS_CYC
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic phase_tick,
  input wire logic [4:0] phase,
  input wire logic int_op,
  input wire logic [23:0] cw42_word,
  input wire logic [23:0] operand_in,
  input wire logic arm_set,
  input wire logic disarm,
  input wire logic rc2_seq,
  input wire logic write_seq,
  input wire logic cw_wc_zero,
  input wire logic int_grant,
  input wire logic exf_rseq,
  input wire logic paper_tape_unit_sel,
  input wire logic [10:0] instr,
  input wire logic con_grant,
  input wire logic con_xfer,
  input wire logic [23:0] con_cw,
  input wire logic interrupt_service_sequence,
  input wire logic [14:0] mem_addr,
  input wire logic [23:0] mem_data,
  input wire logic [13:0] prog_addr,
  input wire logic prog_addr_load,
  input wire logic int_armed,
  input wire logic int_oneshot,
  input wire logic int_resync,
  input wire logic buf_term,
  input wire logic [7:0] char_out,
  input wire logic rdr_lockout,
  input wire logic con_set_b21,
  input wire logic con_marker
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Slot events, plain and inside the service sequence
  sequence s_at(logic [4:0] c);
    phase_tick && phase == c;
  endsequence
  sequence s_svc_at(logic [4:0] c);
    interrupt_service_sequence && phase_tick && phase == c;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_svc_enter;
    s_at(PH_6_4) ##0 (int_op && cw42_word[23:14] == 10'h000 && !interrupt_service_sequence)
      |=> interrupt_service_sequence && mem_addr == 15'h0000 && mem_data == 24'h000000;
  endproperty
  property p_tally;
    s_at(PH_6_4) ##0 (cw42_word[23:14] != 10'h000 && !interrupt_service_sequence)
      |=> !interrupt_service_sequence;
  endproperty
  property p_load43;
    s_svc_at(PH_1_1) |=> mem_addr == INT_CW2_ADDR;
  endproperty
  property p_disarm12;
    s_svc_at(PH_1_2) ##0 !arm_set |=> !int_armed;
  endproperty
  property p_load_p;
    s_svc_at(PH_2_3) |=> prog_addr_load && prog_addr == 14'($past(operand_in));
  endproperty
  property p_svc_exit;
    s_svc_at(PH_5_4) |=> !interrupt_service_sequence;
  endproperty
  property p_disarm_clr;
    disarm && !arm_set ##1 !arm_set |-> !int_armed ##[0:2] !int_oneshot;
  endproperty
  property p_resync_clr;
    s_at(PH_4_2) ##0 int_resync |=> !int_resync;
  endproperty
  property p_stay_clear;
    !int_oneshot && !int_armed && !arm_set |=> !int_oneshot;
  endproperty
  property p_term_set;
    s_at(PH_4_4) ##0 (rc2_seq && cw_wc_zero && !int_grant) |=> buf_term;
  endproperty
  property p_term_hold;
    buf_term && !(phase_tick && phase == PH_6_4 && write_seq) |=> buf_term;
  endproperty
  property p_char;
    s_at(PH_3_3) ##0 (exf_rseq && paper_tape_unit_sel) |=> char_out == 8'($past(instr));
  endproperty
  property p_lock_set;
    s_at(PH_5_1) ##0 (exf_rseq && paper_tape_unit_sel && instr[8]) |=> rdr_lockout;
  endproperty
  property p_first_in;
    con_grant && con_xfer && !con_cw[21] |=> con_set_b21 && con_marker;
  endproperty

  ////////////////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_svc_enter: assert property (p_svc_enter) else $error("service entry wrong");
  a_tally: assert property (p_tally) else $error("entry with nonzero tally");
  a_load43: assert property (p_load43) else $error("address 43 not loaded");
  a_disarm12: assert property (p_disarm12) else $error("arm not cleared");
  a_load_p: assert property (p_load_p) else $error("jump address wrong");
  a_svc_exit: assert property (p_svc_exit) else $error("service not ended");
  a_disarm_clr: assert property (p_disarm_clr) else $error("disarm ignored");
  a_resync_clr: assert property (p_resync_clr) else $error("resync held");
  a_stay_clear: assert property (p_stay_clear) else $error("one-shot unarmed");
  a_term_set: assert property (p_term_set) else $error("terminate not set");
  a_term_hold: assert property (p_term_hold) else $error("terminate dropped");
  a_char: assert property (p_char) else $error("character wrong");
  a_lock_set: assert property (p_lock_set) else $error("lockout not set");
  a_first_in: assert property (p_first_in) else $error("first input marks");
endmodule : iotc_checker

bind iotc_top iotc_checker #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) u_chk (.*);

/* File: verif/iotc_periph_model.sv */
// Reader, consoles and time-base oscillator beyond the block's pins.
// Assumes mclk; the bench enables each requester through plain inputs.
`timescale 1ns/10ps
module iotc_periph_model
  import iotc_pkg::*;
#(
  parameter int OSC_HALF = 20
)
(
  input wire logic mclk,
  input wire logic rdr_go,
  input wire logic [NCON-1:0] con_want,
  input wire logic rdr_out_accept,
  input wire logic rdr_in_accept,
  input wire logic rdr_input_active,
  output logic osc_pin,
  output logic rdr_out_req_pin,
  output logic rdr_in_req_pin,
  output logic [NCON-1:0] con_req,
  output logic [NCON*5-1:0] con_addr
);
  int osc_cnt = 0;

  // Quiet pins at time zero
  initial begin
    osc_pin = 1'b1;
    rdr_out_req_pin = 1'b0;
    rdr_in_req_pin = 1'b0;
  end

  // Free-running oscillator; reader drops each request once it is accepted
  always @(negedge mclk) begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1) osc_pin <= ~osc_pin;
    rdr_out_req_pin <= rdr_go && !rdr_out_accept;
    rdr_in_req_pin <= rdr_go && rdr_input_active && !rdr_in_accept;
  end

  // Consoles hold requests while wanted; an idle address shows inverted bits
  always_comb begin
    for (int i = 0; i < NCON; i++) begin
      con_addr[i*5 +: 5] = con_want[i] ? {i[0], 4'(i + 3)} : ~{i[0], 4'(i + 3)};
    end
  end
  assign con_req = con_want;
endmodule : iotc_periph_model

/* File: verif/tb_iotc_top.sv */
// Self-checking bench for the auxiliary I/O interrupt and terminate control.
// Assumes the partner model supplies oscillator, reader and console pins.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_iotc_top
  import iotc_pkg::*;
;
  logic mclk, srst, phase_tick, scan_seq, rw_seq, wc_seq, rc2_seq, write_seq, seq_start;
  logic int_op, int_grant, io_req_pending, arm_set, disarm, cw_wc_zero, shift_area_mode;
  logic osc_pin, exf_rseq, paper_tape_unit_sel, ack_enable, rdr_out_req_pin, rdr_in_req_pin;
  logic con_grant, con_xfer, con_serpar, con_bitsel, rdr_go, con_dir_in;
  logic [4:0] phase;
  logic [23:0] cw42_word, operand_in, con_cw, con_dest, mem_data;
  logic [13:0] prog_addr_in, prog_addr;
  logic [10:0] instr;
  logic [NCON-1:0] con_req, con_want, con_gate;
  logic [NCON*5-1:0] con_addr;
  logic interrupt_service_sequence, prog_addr_load, strobe_upper, operand_clear;
  logic ifetch_enable_set, first_control_word_read_start, int_armed, int_oneshot, int_resync;
  logic buf_term, shift_stop, rdr_ext_func, rdr_lockout, rdr_input_active, rdr_out_accept;
  logic rdr_in_accept, con_set_b21, con_marker, con_update, con_clr_b21;
  logic [14:0] mem_addr;
  logic [7:0] char_out;
  logic [3:0] con_equip, con_width;
  int miscompares = 0, total_checks = 0, n;

  iotc_top #(.HALF_MS_CYCLES(20)) u_dut (.*);
  iotc_periph_model #(.OSC_HALF(20)) u_far (.*);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Clock, access tasks, verdict and watchdog
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic slot(input logic [4:0] code);
    @(negedge mclk);
    phase_tick = 1'b1;
    phase = code;
    @(negedge mclk);
    phase_tick = 1'b0;
  endtask : slot
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse
  task automatic test_done;
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {phase_tick, scan_seq, rw_seq, wc_seq, rc2_seq, write_seq, seq_start, int_op} = '0;
    {int_grant, io_req_pending, arm_set, disarm, cw_wc_zero, shift_area_mode} = '0;
    {exf_rseq, paper_tape_unit_sel, ack_enable, con_grant, con_xfer, rdr_go} = '0;
    {con_serpar, con_bitsel, phase, cw42_word, operand_in, con_cw, con_dest} = '0;
    {prog_addr_in, instr, con_want} = '0;
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    `CHK("idle", 6'h00, {int_armed, int_oneshot, int_resync, buf_term, rdr_lockout, rdr_input_active})
    // Nonzero tally refused, then two full service sequences
    {int_op, prog_addr_in, operand_in, cw42_word} = {1'b1, 14'h0155, 24'hFFABCD, 24'h00C000};
    slot(PH_6_4);
    `CHK("refused", 1'b0, interrupt_service_sequence)
    for (n = 0; n < 2; n++) begin
      cw42_word = 24'h001234;
      io_req_pending = n[0];
      pulse(arm_set);
      slot(PH_6_4);
      `CHK("entry", {1'b1, 39'h0}, {interrupt_service_sequence, mem_addr, mem_data})
      slot(PH_1_1);
      `CHK("addr 43", INT_CW2_ADDR, mem_addr)
      slot(PH_1_2);
      `CHK("armed", 1'b0, int_armed)
      slot(PH_1_3);
      slot(PH_2_1);
      `CHK("save", 14'h0155, mem_data[13:0])
      slot(PH_2_2);
      `CHK("strobe", {1'b1, 14'h0}, {strobe_upper, prog_addr})
      slot(PH_2_3);
      `CHK("jump", {1'b1, 14'h2BCD}, {prog_addr_load, prog_addr})
      slot(PH_3_2);
      `CHK("d clear", 1'b1, operand_clear)
      slot(PH_5_4);
      `CHK("exit", 1'b0, interrupt_service_sequence)
      slot(PH_6_1);
      `CHK("next", {~n[0], n[0]}, {ifetch_enable_set, first_control_word_read_start})
    end
    // Time base: one-shot, resync after the half period, clear, stay clear
    pulse(arm_set);
    for (n = 0; n < 60 && int_oneshot !== 1'b1; n++) @(negedge mclk);
    `CHK("oneshot", 1'b1, int_oneshot)
    repeat (20) @(negedge mclk);
    {rw_seq, scan_seq} = 2'h3;
    slot(PH_3_4);
    `CHK("resync", 1'b1, int_resync)
    slot(PH_4_2);
    `CHK("resync end", 1'b0, int_resync)
    slot(PH_1_3);
    {rw_seq, scan_seq} = 2'h0;
    `CHK("oneshot end", 1'b0, int_oneshot)
    repeat (100) @(negedge mclk);
    `CHK("oneshot idle", 1'b0, int_oneshot)
    pulse(arm_set);
    for (n = 0; n < 60 && int_oneshot !== 1'b1; n++) @(negedge mclk);
    pulse(disarm);
    repeat (3) @(negedge mclk);
    `CHK("disarmed", 2'h0, {int_armed, int_oneshot})
    // Terminate blocked by a grant, held, then cleared by the write 6.4
    {int_op, rc2_seq, cw_wc_zero, int_grant, shift_area_mode} = 5'h0F;
    slot(PH_4_4);
    `CHK("term blocked", 1'b0, buf_term)
    int_grant = 1'b0;
    slot(PH_4_4);
    `CHK("term", 2'h3, {buf_term, shift_stop})
    rc2_seq = 1'b0;
    slot(PH_6_4);
    `CHK("term held", 1'b1, buf_term)
    write_seq = 1'b1;
    slot(PH_6_4);
    `CHK("term end", 1'b0, buf_term)
    // Reader external function with all four enable bits set
    {exf_rseq, paper_tape_unit_sel, ack_enable, write_seq, instr} = {4'hE, 11'h7A5};
    slot(PH_3_3);
    `CHK("char", 8'hA5, char_out)
    slot(PH_5_1);
    `CHK("reader", 2'h3, {rdr_lockout, rdr_input_active})
    {exf_rseq, rdr_go} = 2'h1;
    pulse(seq_start);
    repeat (8) @(negedge mclk);
    `CHK("blocked", 3'h5, {rdr_ext_func, rdr_out_accept, rdr_lockout})
    slot(PH_4_2);
    `CHK("unlock", 1'b0, rdr_lockout)
    repeat (80) @(negedge mclk);
    `CHK("func end", 1'b0, rdr_ext_func)
    for (n = 0; n < 20 && rdr_out_accept !== 1'b1; n++) @(negedge mclk);
    `CHK("accept", 2'h3, {rdr_out_accept, rdr_in_accept})
    {rc2_seq, int_grant} = 2'h2;
    slot(PH_4_4);
    repeat (12) @(negedge mclk);
    `CHK("area end", 2'h0, {rdr_input_active, rdr_in_accept})
    // Consoles 1 and 2 together; widths; first input and marker arrival
    {con_grant, con_want} = 5'h16;
    for (n = 0; n < 20 && con_gate !== 4'h2; n++) @(negedge mclk);
    `CHK("console", 9'h054, {con_gate, con_dir_in, con_equip})
    for (n = 0; n < 5; n++) begin
      {con_serpar, con_bitsel} = (n < 3) ? 2'h0 : {1'b1, n[0]};
      con_cw = {8'h00, 2'(n), 14'h0000};
      repeat (2) @(negedge mclk);
      `CHK("width", (n < 3) ? 4'(n + 1) : (n[0] ? WIDTH_8 : WIDTH_6), con_width)
    end
    {con_serpar, con_cw} = 25'h0;
    pulse(con_xfer);
    `CHK("first in", 2'h3, {con_set_b21, con_marker})
    for (n = 0; n < 3; n++) begin
      con_cw = {2'h0, 1'b1, 5'h00, 2'(n), 14'h0000};
      con_dest = 24'h000001 << ((n == 0) ? 23 : (n == 1) ? 11 : 7);
      pulse(con_xfer);
      `CHK("update", 2'h3, {con_update, con_clr_b21})
    end
    test_done();
  end
endmodule : tb_iotc_top
